// ===== bench/dpc_host_model.sv
`timescale 1ns/1ns
// host side: feeds stream bytes paced by data request
module dpc_host_model
(
  input wire logic pclk,
  input wire logic data_request,
  output logic stream_valid_pin,
  output logic [7:0] stream_byte_pin
);
  // idle byte lines never repeat the last byte sent
  initial
  begin
    stream_valid_pin = 1'b0;
    stream_byte_pin = 8'ha5;
  end
  task automatic send(input int n, input logic [7:0] b);
    int i;
    i = 0;
    while (i < n)
    begin
      @(posedge pclk);
      if (data_request === 1'b1)
      begin
        stream_byte_pin <= b;
        stream_valid_pin <= 1'b1;
        repeat (2) @(posedge pclk);
        stream_valid_pin <= 1'b0;
        stream_byte_pin <= ~b;
        repeat (2) @(posedge pclk);
        i++;
      end
    end
  endtask
endmodule // dpc_host_model

// ===== bench/dpc_tb.sv
`timescale 1ns/1ns
module testbench;
  import dpc_pkg::*;
  // short hold count keeps the run brief
  localparam int REQ = 20;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE = 32'h0000_0001;
  logic pclk = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, decoded_tick_pin = 1'b0;
  // starts unknown so the drop to low at time zero is a real reset edge
  logic presetn;
  logic [31:0] paddr = ZERO, pwdata = ZERO, prdata, rdata;
  logic pready, pslverr, rerr, data_request, clk_half_sel, pll_enable, analog_enable, crystal_out_pin;
  logic [2:0] multiplier_select;
  logic stream_valid_pin;
  logic [7:0] stream_byte_pin;
  int num_errors = 0, n_checks = 0, cyc = 0, n;
  // reset values of the plain registers
  logic [7:0] ri [5] = '{DPC_IDX_CLKMUL, DPC_IDX_VOL, DPC_IDX_RATE, DPC_IDX_AUDATA, DPC_IDX_POS};
  logic [31:0] rv [5] = '{ZERO, ZERO, ONE, 32'h0000_ac45, 32'hffff_ffff};
  always #50 pclk = ~pclk;
  dpc_top #(.REQ_LOW_CYCLES(REQ), .TICKS_PER_SEC(100)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .stream_valid_pin, .stream_byte_pin, .decoded_tick_pin,
    .data_request, .clk_half_sel, .multiplier_select, .pll_enable, .analog_enable, .crystal_out_pin);
  dpc_host_model host_u (.pclk, .data_request, .stream_valid_pin, .stream_byte_pin);
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; read data kept in rdata
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h00_0000, ix, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // the bench timeout ends a missing answer
    do @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // edges until data request is seen high
  task automatic wait_req;
    n = 0;
    while (data_request !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  // hang guard, far above the planned run
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'({crystal_out_pin, data_request, analog_enable}), ZERO);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // clock range goes in at once, without waiting for the request
    apb(1'b1, DPC_IDX_MODE, 32'h0000_8000);
    wait_req();
    // rise is seen one edge after it lands; the write took three edges
    chk(n + 3, REQ + 2);
    chk(32'({crystal_out_pin, analog_enable, clk_half_sel}), 32'h0000_0007);
    $display("test reset done");
    foreach (ri[i])
    begin
      apb(1'b0, ri[i], ZERO);
      chk(rdata, rv[i]);
    end
    apb(1'b0, 8'h20, ZERO);
    chk(rdata, ZERO);
    chk(32'(rerr), ONE);
    for (int i = 7; i >= 0; i--)
    begin
      apb(1'b1, DPC_IDX_CLKMUL, 32'(i) << 13);
      repeat (2) @(posedge pclk);
      chk(32'({pll_enable, multiplier_select}), 32'(i) | (i != 0 ? 32'h0000_0008 : ZERO));
    end
    apb(1'b1, DPC_IDX_CLKMUL, 32'h0000_9800);
    apb(1'b0, DPC_IDX_CLKMUL, ZERO);
    chk({rdata[28:0], multiplier_select}, {29'h0000_9800, 3'h4});
    apb(1'b1, DPC_IDX_TONE, 32'h0000_7a00);
    apb(1'b0, DPC_IDX_TONE, ZERO);
    chk(rdata, 32'h0000_7a00);
    for (int b = 1; b >= 0; b--)
    begin
      apb(1'b1, DPC_IDX_MODE, 32'(b) << 15);
      repeat (2) @(posedge pclk);
      chk(32'(clk_half_sel), 32'(b));
    end
    apb(1'b1, DPC_IDX_AUDATA, 32'h0000_0010);
    apb(1'b0, DPC_IDX_AUDATA, ZERO);
    chk(rdata, 32'h0000_0010);
    $display("test config done");
    apb(1'b1, DPC_IDX_RATE, 32'h0000_0003);
    apb(1'b1, DPC_IDX_VOL, 32'h0000_ffff);
    apb(1'b1, DPC_IDX_MODE, 32'h0000_0004);
    repeat (DPC_SOFT_WAIT_CYC) @(posedge pclk);
    chk(32'(data_request), ZERO);
    wait_req();
    chk(32'(n + DPC_SOFT_WAIT_CYC >= REQ && n + DPC_SOFT_WAIT_CYC <= REQ + 4), ONE);
    apb(1'b0, DPC_IDX_RATE, ZERO);
    chk(rdata, 32'h0000_0003);
    chk(32'(analog_enable), ZERO);
    apb(1'b1, DPC_IDX_VOL, ZERO);
    repeat (2)
    begin
      decoded_tick_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      decoded_tick_pin <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    chk(32'(analog_enable), ONE);
    apb(1'b0, DPC_IDX_DECTIME, ZERO);
    chk(rdata, 32'h0000_0002);
    $display("test soft reset done");
    // ten bytes inside one short second while fast play stays on
    apb(1'b1, DPC_IDX_DECTIME, ZERO);
    host_u.send(10, 8'h00);
    repeat (60) @(posedge pclk);
    apb(1'b0, DPC_IDX_NOMINAL_BYTE_RATE, ZERO);
    chk(rdata, 32'h0000_000a);
    apb(1'b1, DPC_IDX_HDRSET, 32'h4f67_0010);
    apb(1'b0, DPC_IDX_HDRHI, ZERO);
    chk(rdata, 32'h0000_4f67);
    apb(1'b0, DPC_IDX_STATUS, ZERO);
    chk(32'(rdata[DPC_ST_JUMP_INHIBIT]), ZERO);
    apb(1'b1, DPC_IDX_MODE, 32'h0000_0008);
    host_u.send(31, 8'h00);
    apb(1'b0, DPC_IDX_MODE, ZERO);
    chk(32'(rdata[3]), ONE);
    host_u.send(1, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, i == 0 ? DPC_IDX_MODE : DPC_IDX_HDRLO + 8'(i - 1), ZERO);
      chk(rdata & (i == 0 ? 32'h0000_0008 : 32'hffff_ffff), ZERO);
    end
    apb(1'b0, DPC_IDX_STATUS, ZERO);
    chk(32'(rdata[DPC_ST_JUMP_INHIBIT]), ONE);
    $display("test cancel done");
    conclude();
  end
endmodule // testbench

// ===== bench/dpc_top_sva.sv
`timescale 1ns/1ns
module dpc_chk
  import dpc_pkg::*;
#(
  parameter int REQ_LOW_CYCLES = 20
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic data_request,
  input wire logic clk_half_sel,
  input wire logic [2:0] multiplier_select,
  input wire logic pll_enable,
  input wire logic analog_enable,
  input wire logic crystal_out_pin
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // slack of one edge either way on the hold count
  localparam int LO = REQ_LOW_CYCLES - 1;
  localparam int HI = REQ_LOW_CYCLES + 1;
  // write access edge and register index
  logic wr;
  logic [7:0] idx;
  // edges seen with data request low
  logic [15:0] low_cnt;
  assign wr = psel && penable && pwrite;
  assign idx = paddr[9:2];
  // counter clears whenever data request is up
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) low_cnt <= 16'h0000;
    else low_cnt <= data_request ? 16'h0000 : low_cnt + 16'h0001;
  a_reset_quiet: assert property (disable iff (1'b0) !presetn |-> !data_request && !crystal_out_pin)
    else $error("active output in reset");
  a_range_half: assert property (wr && idx == DPC_IDX_MODE |-> ##2 clk_half_sel == $past(pwdata[15], 2))
    else $error("range bit wrong");
  a_mult_follow: assert property (wr && idx == DPC_IDX_CLKMUL |-> ##2 multiplier_select == $past(pwdata[15:13], 2))
    else $error("multiplier wrong");
  a_pll_matches: assert property (pll_enable == (multiplier_select != 3'h0))
    else $error("pll state wrong");
  a_analog_follow: assert property (wr && idx == DPC_IDX_VOL |-> ##2 analog_enable == ($past(pwdata[15:0], 2) != 16'hffff))
    else $error("analog state wrong");
  a_soft_drop: assert property (wr && idx == DPC_IDX_MODE && pwdata[2] |-> ##2 !data_request)
    else $error("request not dropped");
  a_request_hold: assert property ($rose(data_request) |-> low_cnt >= LO && low_cnt <= HI)
    else $error("request low time wrong");
  a_pready_access: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("no ready in access");
endmodule // dpc_chk
bind dpc_top dpc_chk #(.REQ_LOW_CYCLES(REQ_LOW_CYCLES)) chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .data_request, .clk_half_sel, .multiplier_select, .pll_enable, .analog_enable,
  .crystal_out_pin);

// ===== rtl/dpc_pkg.sv
// Functional notes
// - single 12.288 MHz clock, rates to 48000 Hz; timing constants here assume 10.0 MHz (DPC_CLK_MHZ, DPC_TICKS_PER_SEC)
// - clock range bit halves incoming clock
// - async reset restores all registers and state
// - reset is powerdown: clocks stopped, crystal pin low
// - outputs default during reset, inputs released
// - data request low 22000 cycles after reset
// - clock multiplier 1.0x to 5.0x, reset 1.0x
// - soft reset holds data request low 22000 cycles
// - zero multiplier selects 1.0x, pll off
// - low sample rate value slows audio ticks
// - volume all ones disables analog drivers
// - no decodable data clears both header registers
// - cancel bit self clears after stream drains
// - play rate persists, 1 means normal speed
// - nominal byte rate ignores fast play
// - jump inhibit flag blocks host jumps
// - elapsed seconds ignore jumps, count decoded data
// - exact position reads -1 without time info
// - top three multiplier bits pick 1.0x..5.0x
package dpc_pkg;
  // register indices; the apb byte address is four times the index
  localparam logic [7:0] DPC_IDX_MODE = 8'h00;
  localparam logic [7:0] DPC_IDX_STATUS = 8'h01;
  localparam logic [7:0] DPC_IDX_TONE = 8'h02;
  localparam logic [7:0] DPC_IDX_CLKMUL = 8'h03;
  localparam logic [7:0] DPC_IDX_DECTIME = 8'h04;
  localparam logic [7:0] DPC_IDX_AUDATA = 8'h05;
  localparam logic [7:0] DPC_IDX_HDRLO = 8'h08;
  localparam logic [7:0] DPC_IDX_HDRHI = 8'h09;
  localparam logic [7:0] DPC_IDX_VOL = 8'h0b;
  localparam logic [7:0] DPC_IDX_RATE = 8'h10;
  localparam logic [7:0] DPC_IDX_NOMINAL_BYTE_RATE = 8'h11;
  localparam logic [7:0] DPC_IDX_POS = 8'h12;
  localparam logic [7:0] DPC_IDX_FILL = 8'h13;
  localparam logic [7:0] DPC_IDX_HDRSET = 8'h14;
  // mode register fields
  localparam int DPC_MODE_SOFT_RESET = 2;
  localparam int DPC_MODE_CANCEL = 3;
  localparam int DPC_MODE_CLK_RANGE = 15;
  // status register fields
  localparam int DPC_ST_JUMP_INHIBIT = 15;
  localparam int DPC_ST_ANALOG_OFF = 3;
  localparam int DPC_ST_PLL_ON = 2;
  localparam int DPC_ST_IDLE = 1;
  localparam int DPC_ST_BUSY = 0;
  // clock multiplier field position
  localparam int DPC_MULT_LSB = 13;
  // reset values and the volume off code
  localparam logic [15:0] DPC_VOL_RESET = 16'h0000;
  localparam logic [15:0] DPC_VOL_OFF = 16'hffff;
  localparam logic [15:0] DPC_ZERO16 = 16'h0000;
  localparam logic [15:0] DPC_RATE_NORMAL = 16'h0001;
  localparam logic [15:0] DPC_AUDATA_RESET = 16'hac45;
  localparam logic [31:0] DPC_POS_NONE = 32'hffff_ffff;
  localparam logic [7:0] DPC_FILL_RESET = 8'h00;
  // timing
  localparam int DPC_REQ_LOW_CYCLES = 22000;
  localparam real DPC_SOFT_WAIT_US = 2.0;
  localparam real DPC_CLK_MHZ = 10.0;
  localparam int DPC_SOFT_WAIT_CYC = int'($ceil(DPC_SOFT_WAIT_US * DPC_CLK_MHZ));
  // bytes the cancel must drain before clearing
  localparam int DPC_CANCEL_BYTES = 32;
  localparam int DPC_TICKS_PER_SEC = 10000000;
  // recovery states
  typedef enum logic [1:0] {
    DPC_ST_HOLD = 2'b00,
    DPC_ST_READY = 2'b01,
    DPC_ST_SOFT = 2'b10
  } dpc_state_type;
endpackage

// ===== rtl/dpc_top.sv
`timescale 1ns/1ns
module dpc_top
#(
  parameter int REQ_LOW_CYCLES = dpc_pkg::DPC_REQ_LOW_CYCLES,
  parameter int TICKS_PER_SEC = dpc_pkg::DPC_TICKS_PER_SEC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stream_valid_pin,
  input wire logic [7:0] stream_byte_pin,
  input wire logic decoded_tick_pin,
  output logic data_request,
  output logic clk_half_sel,
  output logic [2:0] multiplier_select,
  output logic pll_enable,
  output logic analog_enable,
  output logic crystal_out_pin
);
  import dpc_pkg::*;

  // apb decode: one wait-free access phase
  logic setup_hit;
  logic wr_hit;
  logic [7:0] widx;
  logic [15:0] wd;
  assign setup_hit = psel && !penable;
  assign wr_hit = psel && penable && pwrite;
  assign widx = paddr[9:2];
  assign wd = pwdata[15:0];

  // pin synchronisers, two flops each
  // byte lines cross per bit; only the strobe path is used here,
  // so a byte caught mid-change cannot do harm
  logic sv_s1_reg, sv_s2_reg, dt_s1_reg, dt_s2_reg, dt_d_reg;
  logic [7:0] sb_s1_reg, sb_s2_reg;
  logic sv_d_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sv_s1_reg <= 1'b0;
      sv_s2_reg <= 1'b0;
      sv_d_reg <= 1'b0;
      sb_s1_reg <= 8'h00;
      sb_s2_reg <= 8'h00;
      dt_s1_reg <= 1'b0;
      dt_s2_reg <= 1'b0;
      dt_d_reg <= 1'b0;
    end
    else
    begin
      sv_s1_reg <= stream_valid_pin;
      sv_s2_reg <= sv_s1_reg;
      sv_d_reg <= sv_s2_reg;
      sb_s1_reg <= stream_byte_pin;
      sb_s2_reg <= sb_s1_reg;
      dt_s1_reg <= decoded_tick_pin;
      dt_s2_reg <= dt_s1_reg;
      dt_d_reg <= dt_s2_reg;
    end
  end
  // byte strobe on rising valid edge (byte rate skips it in hold; cancel count does not)
  // edge detect flops reset low to match idle pins, so no false strobe
  logic byte_stb;
  logic sec_tick;
  assign byte_stb = sv_s2_reg && !sv_d_reg;
  assign sec_tick = dt_s2_reg && !dt_d_reg;

  // software registers
  logic [15:0] mode_reg, tone_reg, clkmul_reg, audata_reg, vol_reg, rate_reg;
  logic [15:0] hdrlo_reg, hdrhi_reg, nominal_byte_rate_reg, dectime_reg;
  logic [31:0] pos_reg;
  logic [7:0] fill_reg;
  // set while a jump would corrupt the stream
  logic jump_inhibit_reg;
  // reset recovery state
  dpc_state_type state_reg;
  // bytes seen since cancel was set
  logic [15:0] cancel_cnt_reg;
  logic soft_go;
  logic cancel_done;
  // soft reset request from a mode write
  assign soft_go = wr_hit && widx == DPC_IDX_MODE && wd[DPC_MODE_SOFT_RESET];
  assign cancel_done = mode_reg[DPC_MODE_CANCEL] && byte_stb &&
                       cancel_cnt_reg == 16'(DPC_CANCEL_BYTES - 1);

  // async reset of configuration
  // soft reset leaves these alone, so volume and play rate persist
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tone_reg <= DPC_ZERO16;
      clkmul_reg <= DPC_ZERO16;
      audata_reg <= DPC_AUDATA_RESET;
      vol_reg <= DPC_VOL_RESET;
      // play rate normal only on chip reset
      rate_reg <= DPC_RATE_NORMAL;
      fill_reg <= DPC_FILL_RESET;
    end
    else if (wr_hit)
    begin
      case (widx)
        DPC_IDX_TONE: tone_reg <= wd;
        DPC_IDX_CLKMUL: clkmul_reg <= wd;
        DPC_IDX_AUDATA: audata_reg <= wd;
        DPC_IDX_VOL: vol_reg <= wd;
        DPC_IDX_RATE: rate_reg <= wd;
        DPC_IDX_FILL: fill_reg <= wd[7:0];
        default: ;
      endcase
    end
  end

  // mode register, cancel bit self-clears
  // a host write beats the drain clear, so a fresh cancel is never lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_reg <= DPC_ZERO16;
    else if (wr_hit && widx == DPC_IDX_MODE)
      // soft reset bit is a command, not stored
      mode_reg <= wd & ~(16'h0001 << DPC_MODE_SOFT_RESET);
    else if (cancel_done)
      mode_reg[DPC_MODE_CANCEL] <= 1'b0;
  end

  // cancel drain byte counter
  // counts stream byte strobes only while the cancel bit is set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cancel_cnt_reg <= DPC_ZERO16;
    else if (!mode_reg[DPC_MODE_CANCEL] || cancel_done)
      cancel_cnt_reg <= DPC_ZERO16;
    else if (byte_stb)
      cancel_cnt_reg <= cancel_cnt_reg + 16'h0001;
  end

  // request-low counter and recovery machine
  // counter sized for the default hold; a larger count needs a wider one
  logic [15:0] hold_cnt_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= DPC_ST_HOLD;
      hold_cnt_reg <= DPC_ZERO16;
    end
    else
    begin
      case (state_reg)
        DPC_ST_HOLD:
        begin
          if (hold_cnt_reg == 16'(REQ_LOW_CYCLES - 1))
            state_reg <= DPC_ST_READY;
          else
            hold_cnt_reg <= hold_cnt_reg + 16'h0001;
        end
        DPC_ST_READY:
        begin
          if (soft_go)
            state_reg <= DPC_ST_SOFT;
        end
        DPC_ST_SOFT:
        begin
          // this state already counts as one low cycle, so the soft
          // hold ends after the same count as a chip reset
          hold_cnt_reg <= 16'h0001;
          state_reg <= DPC_ST_HOLD;
        end
        default: state_reg <= DPC_ST_HOLD;
      endcase
    end
  end
  // request stays low in every state but ready
  logic in_hold;
  assign in_hold = state_reg != DPC_ST_READY;

  // decode status: header, time, rate, position
  logic [31:0] sec_cnt_reg;
  logic [15:0] bytes_sec_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hdrlo_reg <= DPC_ZERO16;
      hdrhi_reg <= DPC_ZERO16;
      dectime_reg <= DPC_ZERO16;
      nominal_byte_rate_reg <= DPC_ZERO16;
      pos_reg <= DPC_POS_NONE;
      jump_inhibit_reg <= 1'b1;
      sec_cnt_reg <= 32'h0000_0000;
      bytes_sec_reg <= DPC_ZERO16;
    end
    else if (state_reg == DPC_ST_SOFT)
    begin
      hdrlo_reg <= DPC_ZERO16;
      hdrhi_reg <= DPC_ZERO16;
      dectime_reg <= DPC_ZERO16;
      nominal_byte_rate_reg <= DPC_ZERO16;
      pos_reg <= DPC_POS_NONE;
      jump_inhibit_reg <= 1'b1;
      sec_cnt_reg <= 32'h0000_0000;
      bytes_sec_reg <= DPC_ZERO16;
    end
    else
    begin
      // drained stream forbids jumps again
      // the drain event wins over a header post in the same cycle
      if (cancel_done)
      begin
        hdrlo_reg <= DPC_ZERO16;
        hdrhi_reg <= DPC_ZERO16;
        jump_inhibit_reg <= 1'b1;
      end
      // header value posted by an apb write to the header set index
      else if (wr_hit && widx == DPC_IDX_HDRSET)
      begin
        hdrhi_reg <= pwdata[31:16];
        hdrlo_reg <= wd;
        jump_inhibit_reg <= 1'b0;
      end
      if (wr_hit && widx == DPC_IDX_DECTIME)
        dectime_reg <= wd;
      else if (sec_tick)
        dectime_reg <= dectime_reg + 16'h0001;
      // byte rate over wall time, unscaled
      if (wr_hit && widx == DPC_IDX_DECTIME)
      begin
        sec_cnt_reg <= 32'h0000_0000;
        bytes_sec_reg <= DPC_ZERO16;
      end
      else if (sec_cnt_reg == 32'(TICKS_PER_SEC - 1))
      begin
        sec_cnt_reg <= 32'h0000_0000;
        nominal_byte_rate_reg <= bytes_sec_reg;
        bytes_sec_reg <= DPC_ZERO16;
      end
      else
      begin
        sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
        if (byte_stb && !in_hold)
          bytes_sec_reg <= bytes_sec_reg + 16'h0001;
      end
      if (wr_hit && widx == DPC_IDX_POS)
        pos_reg <= pwdata;
    end
  end

  // outputs and pin drive, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_request <= 1'b0;
      clk_half_sel <= 1'b0;
      multiplier_select <= 3'b000;
      pll_enable <= 1'b0;
      analog_enable <= 1'b0;
      crystal_out_pin <= 1'b0;
    end
    else
    begin
      data_request <= !in_hold && !(state_reg == DPC_ST_READY && soft_go);
      clk_half_sel <= mode_reg[DPC_MODE_CLK_RANGE];
      multiplier_select <= clkmul_reg[15:DPC_MULT_LSB];
      pll_enable <= clkmul_reg[15:DPC_MULT_LSB] != 3'b000;
      analog_enable <= vol_reg != DPC_VOL_OFF;
      // crystal pin released once out of powerdown
      crystal_out_pin <= 1'b1;
    end
  end

  // apb read data, registered at setup
  // registering here costs nothing: pready is one cycle late anyway
  // status bits: jump inhibit, analog off, pll on, idle, hold
  // these bit positions follow the package field constants
  logic [15:0] status_val;
  assign status_val = {jump_inhibit_reg, 11'h000, vol_reg == DPC_VOL_OFF,
                       clkmul_reg[15:DPC_MULT_LSB] != 3'b000, !sv_s2_reg, in_hold};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end
    else
    begin
      pready <= setup_hit;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (setup_hit)
      begin
        case (paddr[9:2])
          DPC_IDX_MODE: prdata <= {16'h0000, mode_reg};
          DPC_IDX_STATUS: prdata <= {16'h0000, status_val};
          DPC_IDX_TONE: prdata <= {16'h0000, tone_reg};
          DPC_IDX_CLKMUL: prdata <= {16'h0000, clkmul_reg};
          DPC_IDX_DECTIME: prdata <= {16'h0000, dectime_reg};
          DPC_IDX_AUDATA: prdata <= {16'h0000, audata_reg};
          DPC_IDX_HDRLO: prdata <= {16'h0000, hdrlo_reg};
          DPC_IDX_HDRHI: prdata <= {16'h0000, hdrhi_reg};
          DPC_IDX_VOL: prdata <= {16'h0000, vol_reg};
          DPC_IDX_RATE: prdata <= {16'h0000, rate_reg};
          DPC_IDX_NOMINAL_BYTE_RATE: prdata <= {16'h0000, nominal_byte_rate_reg};
          DPC_IDX_POS: prdata <= pos_reg;
          DPC_IDX_FILL: prdata <= {24'h00_0000, fill_reg};
          DPC_IDX_HDRSET: prdata <= 32'h0000_0000;
          // unmapped address answers with error
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // dpc_top
